// [hdl/store_xfer_pkg.sv]
// Package: constants and types for the array store register transfer block
package store_xfer_pkg;
   // ****************************************
   // Operations and step codes
   // ****************************************
   typedef enum logic [2:0] {
      OP_ROW_AND = 3'h0, // plane_row_and_reduce
      OP_COL_AND = 3'h1, // plane_column_and_reduce
      OP_SET_ONES = 3'h2, // register_set_ones
      OP_LD_WORD = 3'h3, // load_store_word
      OP_LD_OWORD = 3'h4, // load_orthogonal_word
      OP_LD_ROW = 3'h5, // load_store_row
      OP_LD_COL = 3'h6, // load_store_column
      OP_ST_INV_ACT = 3'h7 // store_inverted_activity_plane
   } op_type;
   typedef enum logic [1:0] {
      STEP_NONE = 2'h0,
      STEP_INC = 2'h1,
      STEP_DEC = 2'h2
   } step_type;
   localparam int PLANE_W = 16;
   localparam int IDX_W = 16;
   localparam int CTRL_W = 32;
   // Offset register field layout
   localparam int OFFS_PLANE_LSB = 16;
   localparam int OFFS_ROW_LSB = 0;
   // destination_select_field: bit 4 picks edge_register
   localparam logic [4:0] DEST_EDGE = 5'h10;
   // ****************************************
   // Instruction carrier
   // ****************************************
   typedef struct packed {
      op_type op;
      logic [4:0] dest;
      logic [PLANE_W-1:0] plane;
      logic [IDX_W-1:0] row;
      logic [3:0] word;
      logic offs_en;
      logic [3:0] offset_register_select;
      step_type step;
      logic step_row; // stepped_part_select: 1 steps row index on row and column loads
   } instr_type;
   // ****************************************
   // Register map (byte offsets)
   // ****************************************
   localparam logic [7:0] OFS_CTRL0 = 8'h00; // 16 control regs, 4 apart
   localparam logic [7:0] OFS_EDGE = 8'h40;
   localparam logic [7:0] OFS_BASE = 8'h44;
   localparam logic [7:0] OFS_LIMIT = 8'h48;
   localparam logic [7:0] OFS_STATUS = 8'h4C;
   localparam logic [7:0] OFS_ENABLE = 8'h50;
   localparam logic [7:0] OFS_CLEAR = 8'h54;
   localparam int EV_DONE = 0;
   localparam int EV_RANGE = 1;
   localparam logic [1:0] EV_NONE = 2'h0;
   localparam logic [PLANE_W-1:0] BASE_RST = 16'h0000;
   localparam logic [PLANE_W-1:0] LIMIT_RST = 16'hFFFF;
   localparam logic [CTRL_W-1:0] ONES32 = 32'hFFFF_FFFF;
   localparam logic [CTRL_W-1:0] ZERO32 = 32'h0000_0000;
endpackage : store_xfer_pkg

// [hdl/store_xfer.sv]
// Module: array store to register transfer datapath
// Operation
// [RULE_01] Row reduce: destination gets AND across all rows of the plane.
// [RULE_02] Column reduce: destination gets AND across all columns of the plane.
// [RULE_03] Edge register takes whole result; control register takes low 32 bits. The code leaves the edge register unchanged for word loads.
// [RULE_04] Plane mode: address from effective plane field, row index ignored.
// [RULE_05] Effective plane outside program block range raises an error.
// [RULE_06] Inside a loop, step codes increment or decrement the address.
// [RULE_07] Effective address is instruction plus modifier fields, plus/minus iteration.
// [RULE_08] Destination select field picks a control register or edge register.
// [RULE_09] Set ones writes all ones into the chosen control register.
// [RULE_10] Word load copies the word at plane, row and word into register.
// [RULE_11] Orthogonal word: plane and row pick a column, word picks within it.
// [RULE_12] Row load copies the addressed store row into the destination.
// [RULE_13] Column load copies the addressed store column into the destination.
// [RULE_14] Row mode: address formed from plane and row index together.
// [RULE_15] Row and column loads step row index or plane as selected.
// [RULE_16] Row or column into control register keeps the low 32 bits.
// [RULE_17] Inverted activity plane is written to the addressed store plane.
// [RULE_18] Edge register width is a parameter; control registers are 32 bits.
`timescale 1ns/100ps
`default_nettype none
module store_xfer #(
   parameter int EDGE_SIZE = 32 // [RULE_18]
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Instruction issue and loop context
   input wire logic instr_valid,
   input wire store_xfer_pkg::instr_type instr,
   input wire logic loop_active,
   input wire logic [15:0] loop_iter,
   input wire logic [EDGE_SIZE*EDGE_SIZE-1:0] activity_plane,
   output logic busy,
   // Array store
   output logic store_rd,
   output logic store_wr,
   output logic [store_xfer_pkg::PLANE_W-1:0] store_plane,
   output logic [EDGE_SIZE*EDGE_SIZE-1:0] store_wdata,
   input wire logic [EDGE_SIZE*EDGE_SIZE-1:0] store_rdata,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   output logic [EDGE_SIZE-1:0] edge_out
);
   import store_xfer_pkg::*;
   localparam int EW = EDGE_SIZE;
   localparam int RW = (EW > 1) ? $clog2(EW) : 1;
   localparam int AW = PLANE_W + RW;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_APPLY = 2'b10
   } state_type;

   state_type state_reg;
   logic [CTRL_W-1:0] ctrl_reg [16];
   logic [EW-1:0] edge_reg;
   logic [PLANE_W-1:0] base_reg;
   logic [PLANE_W-1:0] limit_reg;
   logic [1:0] status_reg;
   logic [1:0] enable_reg;
   op_type op_reg;
   logic [4:0] dest_reg;
   logic [RW-1:0] row_reg;
   logic [3:0] word_reg;

   // ****************************************
   // Effective address
   // ****************************************
   logic [CTRL_W-1:0] offs_val;
   logic [PLANE_W-1:0] offs_plane;
   logic [RW-1:0] offs_row;
   logic [AW-1:0] base_sum;
   logic [AW-1:0] step_amt;
   logic [AW-1:0] eff_addr;
   logic [PLANE_W-1:0] eff_plane;
   logic [RW-1:0] eff_row;
   logic plane_mode;
   logic range_bad;
   logic accept;

   assign accept = instr_valid && (state_reg == ST_IDLE);
   assign offs_val = instr.offs_en ? ctrl_reg[instr.offset_register_select] : ZERO32;
   assign offs_plane = offs_val[OFFS_PLANE_LSB +: PLANE_W];
   assign offs_row = offs_val[OFFS_ROW_LSB +: RW];
   assign plane_mode = (instr.op == OP_ROW_AND) || (instr.op == OP_COL_AND) ||
                       (instr.op == OP_ST_INV_ACT);

   always_comb begin
      // Carry out of the row index ripples into the plane part
      if (plane_mode) begin
         base_sum = {instr.plane + offs_plane, {RW{1'b0}}}; // [RULE_04] [RULE_07]
      end else begin
         base_sum = {instr.plane, instr.row[RW-1:0]} + {offs_plane, offs_row}; // [RULE_14] [RULE_07]
      end
      step_amt = '0;
      if (loop_active && (instr.step != STEP_NONE)) begin // [RULE_06]
         if (!plane_mode && instr.step_row && (instr.op != OP_LD_WORD) && (instr.op != OP_LD_OWORD)) begin
            step_amt = AW'(loop_iter); // [RULE_15]
         end else begin
            step_amt = {loop_iter, {RW{1'b0}}}; // [RULE_15]
         end
      end
      if (instr.step == STEP_DEC) begin
         eff_addr = base_sum - step_amt; // [RULE_06]
      end else begin
         eff_addr = base_sum + step_amt; // [RULE_06]
      end
   end

   assign eff_plane = eff_addr[AW-1:RW];
   assign eff_row = eff_addr[RW-1:0];
   assign range_bad = (eff_plane < base_reg) || (eff_plane > limit_reg); // [RULE_05]

   // ****************************************
   // Plane reductions and selections
   // ****************************************
   logic [EW-1:0] row_and;
   logic [EW-1:0] col_and;
   logic [EW-1:0] col_mat [EW];

   genvar g;
   generate
      for (g = 0; g < EW; g++) begin : g_red
         genvar h;
         for (h = 0; h < EW; h++) begin : g_col
            assign col_mat[g][h] = store_rdata[h*EW + g];
         end
         assign row_and[g] = &store_rdata[g*EW +: EW]; // [RULE_02]
         assign col_and[g] = &col_mat[g]; // [RULE_01]
      end
   endgenerate

   logic [EW-1:0] line;
   logic [EW+31:0] line_ext;
   logic [EW-1:0] result;

   always_comb begin
      line = store_rdata[row_reg*EW +: EW]; // [RULE_12]
      if ((op_reg == OP_LD_COL) || (op_reg == OP_LD_OWORD)) begin
         line = col_mat[row_reg]; // [RULE_13] [RULE_11]
      end
      line_ext = {32'h0000_0000, line} >> {word_reg, 5'b0_0000}; // [RULE_10] [RULE_11]
      case (op_reg)
         OP_ROW_AND: result = col_and; // [RULE_01]
         OP_COL_AND: result = row_and; // [RULE_02]
         OP_LD_WORD, OP_LD_OWORD: result = EW'(line_ext[31:0]);
         default: result = line;
      endcase
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         op_reg <= OP_ROW_AND;
         dest_reg <= 5'h00;
         row_reg <= '0;
         word_reg <= 4'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (accept && !range_bad && (instr.op != OP_SET_ONES) && (instr.op != OP_ST_INV_ACT)) begin
                  state_reg <= ST_WAIT;
               end
               if (accept) begin
                  op_reg <= instr.op;
                  dest_reg <= instr.dest; // [RULE_08]
                  row_reg <= eff_row;
                  word_reg <= instr.word;
               end
            end
            ST_WAIT: state_reg <= ST_APPLY;
            ST_APPLY: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Store port; a plane is the unit of every access
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         store_rd <= 1'b0;
         store_wr <= 1'b0;
         store_plane <= '0;
         store_wdata <= '0;
      end else begin
         store_rd <= accept && !range_bad && (instr.op != OP_SET_ONES) && (instr.op != OP_ST_INV_ACT);
         store_wr <= accept && !range_bad && (instr.op == OP_ST_INV_ACT);
         if (accept) begin
            store_plane <= eff_plane;
            store_wdata <= ~activity_plane; // [RULE_17]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         busy <= 1'b0;
      end else begin
         busy <= (accept && !range_bad && (instr.op != OP_SET_ONES) && (instr.op != OP_ST_INV_ACT)) ||
                 (state_reg == ST_WAIT);
      end
   end

   // ****************************************
   // Destination registers
   // ****************************************
   logic wr_ctrl;
   logic set_ones;
   logic apply;

   assign apply = (state_reg == ST_APPLY);
   assign wr_ctrl = reg_wr && (reg_addr < OFS_EDGE);
   assign set_ones = accept && (instr.op == OP_SET_ONES) && !instr.dest[4];

   // Instruction results win over a software write in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < 16; i++) begin
            ctrl_reg[i] <= ZERO32;
         end
      end else begin
         if (wr_ctrl) begin
            ctrl_reg[reg_addr[5:2]] <= reg_wdata;
         end
         if (set_ones) begin
            ctrl_reg[instr.dest[3:0]] <= ONES32; // [RULE_09]
         end
         if (apply && !dest_reg[4]) begin
            ctrl_reg[dest_reg[3:0]] <= CTRL_W'({32'h0000_0000, result}); // [RULE_03] [RULE_16]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         edge_reg <= '0;
      end else if (apply && dest_reg[4] && (op_reg != OP_LD_WORD) && (op_reg != OP_LD_OWORD)) begin
         edge_reg <= result; // [RULE_03] [RULE_08]
      end
   end
   assign edge_out = edge_reg;

   // ****************************************
   // Configuration, events and interrupt
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         base_reg <= BASE_RST;
         limit_reg <= LIMIT_RST;
         enable_reg <= EV_NONE;
      end else if (reg_wr) begin
         if (reg_addr == OFS_BASE) begin
            base_reg <= reg_wdata[PLANE_W-1:0];
         end
         if (reg_addr == OFS_LIMIT) begin
            limit_reg <= reg_wdata[PLANE_W-1:0];
         end
         if (reg_addr == OFS_ENABLE) begin
            enable_reg <= reg_wdata[1:0];
         end
      end
   end

   logic [1:0] ev_set;
   logic [1:0] ev_clr;

   always_comb begin
      ev_set = EV_NONE;
      ev_set[EV_DONE] = apply || set_ones || (accept && !range_bad && (instr.op == OP_ST_INV_ACT));
      ev_set[EV_RANGE] = accept && range_bad && (instr.op != OP_SET_ONES); // [RULE_05]
      ev_clr = (reg_wr && (reg_addr == OFS_CLEAR)) ? reg_wdata[1:0] : EV_NONE;
   end

   // A new event beats a clear of the same bit
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         status_reg <= EV_NONE;
      end else begin
         status_reg <= (status_reg & ~ev_clr) | ev_set;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((status_reg & ~ev_clr) | ev_set) & enable_reg);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reg_rdata <= ZERO32;
      end else if (reg_rd) begin
         if (reg_addr < OFS_EDGE) begin
            reg_rdata <= ctrl_reg[reg_addr[5:2]];
         end else begin
            case (reg_addr)
               OFS_EDGE: reg_rdata <= CTRL_W'({32'h0000_0000, edge_reg});
               OFS_BASE: reg_rdata <= {16'h0000, base_reg};
               OFS_LIMIT: reg_rdata <= {16'h0000, limit_reg};
               OFS_STATUS: reg_rdata <= {30'h0000_0000, status_reg};
               OFS_ENABLE: reg_rdata <= {30'h0000_0000, enable_reg};
               default: reg_rdata <= ZERO32;
            endcase
         end
      end else begin
         reg_rdata <= ZERO32;
      end
   end
endmodule : store_xfer
`default_nettype wire

// [test/store_xfer_monitor.sv]
// Checker: port assertions for the store transfer block
`timescale 1ns/100ps
`default_nettype none
module store_xfer_monitor #(
   parameter int EDGE_SIZE = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Instruction side
   input wire logic instr_valid,
   input wire store_xfer_pkg::instr_type instr,
   input wire logic loop_active,
   input wire logic [15:0] loop_iter,
   input wire logic [EDGE_SIZE*EDGE_SIZE-1:0] activity_plane,
   input wire logic busy,
   // Store side
   input wire logic store_rd,
   input wire logic store_wr,
   input wire logic [store_xfer_pkg::PLANE_W-1:0] store_plane,
   input wire logic [EDGE_SIZE*EDGE_SIZE-1:0] store_wdata,
   input wire logic [EDGE_SIZE-1:0] edge_out
);
   import store_xfer_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ****************************************
   // Read walk
   // ****************************************
   sequence s_read_tail;
      busy ##1 (busy && !store_rd) ##1 !busy;
   endsequence
   sequence s_read_taken;
      $past(instr_valid) && !($past(instr.op) inside {OP_SET_ONES, OP_ST_INV_ACT});
   endsequence
   property p_read_walk;
      store_rd |-> s_read_tail;
   endproperty
   a_read_walk: assert property (p_read_walk) else $error("read walk broken");
   property p_rd_cause;
      store_rd |-> s_read_taken;
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("store read without read op");
   property p_busy_start;
      $rose(busy) |-> store_rd;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy without store read");
   // ****************************************
   // Store write and addressing
   // ****************************************
   property p_wr_cause;
      store_wr |-> $past(instr_valid) && $past(instr.op) == OP_ST_INV_ACT;
   endproperty
   a_wr_cause: assert property (p_wr_cause) else $error("store write without its op");
   property p_inv_data;
      store_wr |-> store_wdata == ~$past(activity_plane);
   endproperty
   a_inv_data: assert property (p_inv_data) else $error("write data not inverted activity");
   property p_excl;
      !(store_rd && store_wr);
   endproperty
   a_excl: assert property (p_excl) else $error("store read and write together");
   property p_plane_mode;
      (store_rd || store_wr) && !$past(instr.offs_en) && !$past(loop_active)
         && $past(instr.op) inside {OP_ROW_AND, OP_COL_AND, OP_ST_INV_ACT} |-> store_plane == $past(instr.plane);
   endproperty
   a_plane_mode: assert property (p_plane_mode) else $error("plane address wrong");
   property p_step;
      store_rd && $past(loop_active) && !$past(instr.offs_en) && $past(instr.op) inside {OP_ROW_AND, OP_COL_AND}
         |-> store_plane == $past(instr.plane) + ($past(instr.step) == STEP_INC ? $past(loop_iter) : 16'h0)
         - ($past(instr.step) == STEP_DEC ? $past(loop_iter) : 16'h0);
   endproperty
   a_step: assert property (p_step) else $error("stepped plane wrong");
   // Edge register only moves as a read op completes
   property p_edge_hold;
      $past(rst_b) && !$fell(busy) |-> $stable(edge_out);
   endproperty
   a_edge_hold: assert property (p_edge_hold) else $error("edge register changed");
endmodule : store_xfer_monitor
bind store_xfer store_xfer_monitor #(.EDGE_SIZE(EDGE_SIZE)) mon (.clk(clk), .rst_b(rst_b),
   .instr_valid(instr_valid), .instr(instr), .loop_active(loop_active), .loop_iter(loop_iter),
   .activity_plane(activity_plane), .busy(busy), .store_rd(store_rd), .store_wr(store_wr),
   .store_plane(store_plane), .store_wdata(store_wdata), .edge_out(edge_out));
`default_nettype wire

// [test/store_model.sv]
// Partner model: array store memory of the processing element grid
`timescale 1ns/100ps
`default_nettype none
module store_model #(
   parameter int EDGE_SIZE = 32,
   parameter int DEPTH = 64
) (
   // Clock
   input wire logic clk,
   // Store access
   input wire logic store_rd,
   input wire logic store_wr,
   input wire logic [15:0] store_plane,
   input wire logic [EDGE_SIZE*EDGE_SIZE-1:0] store_wdata,
   output logic [EDGE_SIZE*EDGE_SIZE-1:0] store_rdata
);
   localparam int AB = $clog2(DEPTH);
   // Planes beyond the depth alias; the tests stay below it
   logic [EDGE_SIZE*EDGE_SIZE-1:0] mem [DEPTH];
   // Data stand one cycle only; the inverse afterwards exposes a late capture
   always @(posedge clk) begin
      if (store_wr) begin
         mem[store_plane[AB-1:0]] <= store_wdata;
      end
      if (store_rd) begin
         store_rdata <= mem[store_plane[AB-1:0]];
      end else begin
         store_rdata <= ~store_rdata;
      end
   end
endmodule : store_model
`default_nettype wire

// [test/array_store_register_transfer_test.sv]
// Testbench: instruction and register port tests for the store transfer block
`timescale 1ns/100ps
`default_nettype none
module array_store_register_transfer_test;
   import store_xfer_pkg::*;
   localparam int SIDE = 36;
   logic clk, rst_b, instr_valid, loop_active, busy, store_rd, store_wr, reg_wr, reg_rd, irq;
   instr_type instr, i;
   logic [15:0] loop_iter, store_plane;
   logic [SIDE*SIDE-1:0] activity_plane, store_wdata, store_rdata, p;
   logic [SIDE-1:0] edge_out, col;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   int err_total, checks;
   store_xfer #(.EDGE_SIZE(SIDE)) dut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
      .loop_active(loop_active), .loop_iter(loop_iter), .activity_plane(activity_plane), .busy(busy),
      .store_rd(store_rd), .store_wr(store_wr), .store_plane(store_plane), .store_wdata(store_wdata),
      .store_rdata(store_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .edge_out(edge_out));
   store_model #(.EDGE_SIZE(SIDE)) store (.clk(clk), .store_rd(store_rd), .store_wr(store_wr),
      .store_plane(store_plane), .store_wdata(store_wdata), .store_rdata(store_rdata));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk("reg_rdata", {32'h0, e}, {32'h0, d});
   endtask : rchk
   task automatic ech(input logic [SIDE-1:0] e);
      chk("edge_out", 64'(e), 64'(edge_out));
   endtask : ech
   // Read ops need three cycles before the next issue
   task automatic run(input instr_type x);
      @(posedge clk);
      instr <= x;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      // Returns on the edge after the result lands, so the next stimulus is edge aligned
      repeat (3) @(posedge clk);
   endtask : run
   function automatic instr_type mk(input op_type o, input logic [4:0] dst, input logic [15:0] pl,
      input logic [15:0] r, input logic [3:0] w);
      mk = '0;
      mk.op = o;
      mk.dest = dst;
      mk.plane = pl;
      mk.row = r;
      mk.word = w;
   endfunction : mk
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      close_out();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      {err_total, checks} = '0;
      {rst_b, instr_valid, loop_active, reg_wr, reg_rd} = '0;
      {instr, loop_iter, activity_plane, reg_addr, reg_wdata} = '0;
      p = '1;
      p[7*SIDE+3] = 1'b0;
      p[35] = 1'b0;
      store.mem[5] = p;
      p = '0;
      p[5*SIDE +: SIDE] = 36'h9_1234_5678;
      store.mem[6] = p;
      col = 36'hA_5A5A_5A5A;
      for (int r = 0; r < SIDE; r++) begin
         p[r*SIDE+2] = col[r];
      end
      store.mem[7] = p;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      rchk(OFS_LIMIT, 32'h0000_FFFF);
      rchk(8'hFC, 32'h0);
      $display("test reset done");
      run(mk(OP_ROW_AND, DEST_EDGE, 16'h5, 16'h9, 4'h0));
      ech(36'h7_FFFF_FFF7);
      run(mk(OP_ROW_AND, 5'h1, 16'h5, 16'h0, 4'h0));
      rchk(8'h04, 32'hFFFF_FFF7);
      run(mk(OP_COL_AND, DEST_EDGE, 16'h5, 16'h0, 4'h0));
      ech(36'hF_FFFF_FF7E);
      run(mk(OP_COL_AND, 5'h2, 16'h5, 16'h0, 4'h0));
      rchk(8'h08, 32'hFFFF_FF7E);
      $display("test reduce done");
      wr(8'h04, 32'h0002_0001);
      i = mk(OP_LD_ROW, DEST_EDGE, 16'h4, 16'h4, 4'h0);
      i.offs_en = 1'b1;
      i.offset_register_select = 4'h1;
      run(i);
      ech(36'h9_1234_5678);
      i.dest = 5'h3;
      run(i);
      rchk(8'h0C, 32'h1234_5678);
      i.op = OP_LD_WORD;
      i.word = 4'h1;
      run(i);
      rchk(8'h0C, 32'h9);
      run(mk(OP_LD_OWORD, 5'h3, 16'h7, 16'h2, 4'h1));
      rchk(8'h0C, 32'hA);
      run(mk(OP_LD_COL, DEST_EDGE, 16'h7, 16'h2, 4'h0));
      ech(col);
      rchk(OFS_EDGE, 32'h5A5A_5A5A);
      run(mk(OP_SET_ONES, 5'h4, 16'h0, 16'h0, 4'h0));
      rchk(8'h10, ONES32);
      run(mk(OP_SET_ONES, DEST_EDGE, 16'h0, 16'h0, 4'h0));
      ech(col);
      $display("test loads done");
      loop_active <= 1'b1;
      loop_iter <= 16'h3;
      i = mk(OP_ROW_AND, DEST_EDGE, 16'h8, 16'h0, 4'h0);
      i.step = STEP_DEC;
      run(i);
      ech(36'h7_FFFF_FFF7);
      i = mk(OP_COL_AND, DEST_EDGE, 16'h2, 16'h0, 4'h0);
      i.step = STEP_INC;
      run(i);
      ech(36'hF_FFFF_FF7E);
      loop_iter <= 16'h2;
      i = mk(OP_LD_COL, DEST_EDGE, 16'h7, 16'h0, 4'h0);
      i.step = STEP_INC;
      i.step_row = 1'b1;
      run(i);
      ech(col);
      i = mk(OP_LD_ROW, DEST_EDGE, 16'h4, 16'h5, 4'h0);
      i.step = STEP_INC;
      run(i);
      ech(36'h9_1234_5678);
      loop_active <= 1'b0;
      $display("test stepping done");
      activity_plane <= {(SIDE*SIDE/4){4'h3}};
      run(mk(OP_ST_INV_ACT, 5'h0, 16'h9, 16'h0, 4'h0));
      run(mk(OP_ROW_AND, DEST_EDGE, 16'h9, 16'h0, 4'h0));
      ech(36'hC_CCCC_CCCC);
      $display("test store done");
      wr(OFS_CLEAR, 32'h3);
      wr(OFS_LIMIT, 32'h20);
      run(mk(OP_ROW_AND, DEST_EDGE, 16'h30, 16'h0, 4'h0));
      ech(36'hC_CCCC_CCCC);
      chk("irq", 64'h0, {63'h0, irq});
      rd(OFS_STATUS);
      chk("status", 64'h1, {63'h0, d[EV_RANGE]});
      wr(OFS_ENABLE, 32'h2);
      @(posedge clk);
      #1 chk("irq", 64'h1, {63'h0, irq});
      wr(OFS_CLEAR, 32'h2);
      @(posedge clk);
      #1 chk("irq", 64'h0, {63'h0, irq});
      $display("test range done");
      close_out();
   end
endmodule : array_store_register_transfer_test
`default_nettype wire
